// >>> rtl/rsc_handler.sv
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module rsc_handler
    import rsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        hw_trigger,
    input  wire logic        acquiring,
    input  wire logic        meas_summary,
    input  wire logic [7:0]  fault_events,
    output logic             trigger_pulse,
    output logic      [1:0]  local_remote_select,
    output logic             remote_override,
    output logic             irq
);
    rsc_regs_t q;
    rsc_regs_t d;
    logic [31:0] id_word;
    logic [7:0]  poll_status;
    logic [3:0]  op;
    logic        is_query;
    logic        is_bit;
    logic        bad_arg;
    logic        bus_req;

    rsc_id_rom u_id_rom (
        .clk  (clk),
        .addr (q.id_idx),
        .data (id_word)
    );

    function automatic logic [7:0] rsc_upd(input logic [7:0] cur, input logic bitf,
                                           input logic [15:0] idx, input logic [15:0] val);
        logic [7:0] r;
        r = cur;
        if (bitf) begin
            r[idx[2:0]] = val[0];
        end else begin
            r = val[7:0];
        end
        return r;
    endfunction

    function automatic logic [31:0] rsc_pick(input logic [7:0] v, input logic bitf,
                                             input logic [15:0] idx);
        logic [31:0] r;
        r = {24'h000000, v};
        if (bitf) begin
            r = {31'h00000000, v[idx[2:0]]};
        end
        return r;
    endfunction

    // ****************************************************************
    // Status summary
    // ****************************************************************
    always_comb begin
        poll_status = 8'h00;
        poll_status[`RSC_POLL_ACQ_IDLE] = ~acquiring;
        poll_status[`RSC_POLL_CMD_IDLE] = (q.st == RSC_IDLE);
        poll_status[`RSC_POLL_FAULT] = |(q.fault_status & q.cfg.fault_enable_mask);
        poll_status[`RSC_POLL_MEAS] = meas_summary;
    end

    assign op       = q.cmd[3:0];
    assign is_query = q.cmd[`RSC_CMD_QUERY_BIT];
    assign is_bit   = q.cmd[`RSC_CMD_BIT_BIT];
    assign bus_req  = avs_read | avs_write;

    // Argument check for set forms and for the bit index of bit forms
    always_comb begin
        bad_arg = 1'b0;
        if (is_bit) begin
            bad_arg = (q.arg_idx > `RSC_BIT_MAX);
            if (!is_query && q.arg_val > 16'h0001) begin
                bad_arg = 1'b1;
            end
        end else if (!is_query && q.arg_val > `RSC_BYTE_MAX) begin
            bad_arg = 1'b1;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.trigger   = 1'b0;
        d.trig_prev = hw_trigger;
        d.waitreq   = 1'b1;
        d.id_rd     = 1'b0;
        d.fault_status = q.fault_status | fault_events;
        if (!q.waitreq && avs_write && avs_byteenable[0] && avs_address == `RSC_IRQ_STS_OFS) begin
            d.irq_sts = q.irq_sts & ~avs_writedata[2:0];
        end
        if (hw_trigger && !q.trig_prev) begin
            d.trigger = 1'b1;
            d.irq_sts[`RSC_IRQ_TRIGGER] = 1'b1;
        end

        case (q.st)
            RSC_IDLE: begin
                d.waitreq = 1'b1;
            end
            RSC_EXEC: begin
                d.st = RSC_IDLE;
                d.irq_sts[`RSC_IRQ_DONE] = 1'b1;
                d.result = 32'h00000000;
                if (bad_arg && op != `RSC_CMD_IDENT) begin
                    d.result = `RSC_RESULT_BAD;
                    d.irq_sts[`RSC_IRQ_REJECT] = 1'b1;
                    d.event_status[`RSC_EVT_CMD_ERR] = 1'b1;
                end else begin
                    case (op)
                        `RSC_CMD_RESET: begin
                            d.cfg = '0;
                            d.cfg.power_on_clear = q.cfg.power_on_clear;
                        end
                        `RSC_CMD_IDENT: begin
                            d.id_idx = q.arg_idx[`RSC_ID_AW-1:0];
                            d.id_rd  = 1'b1;
                            d.st     = RSC_ANS;
                        end
                        `RSC_CMD_LOCAL: begin
                            if (is_query) begin
                                d.result = {30'h00000000, q.cfg.local_remote_select};
                            end else if (q.arg_val > 16'h0002) begin
                                d.result = `RSC_RESULT_BAD;
                                d.irq_sts[`RSC_IRQ_REJECT] = 1'b1;
                            end else begin
                                d.cfg.local_remote_select = q.arg_val[1:0];
                            end
                        end
                        `RSC_CMD_OVERRIDE: begin
                            if (is_query) begin
                                d.result = {31'h00000000, q.cfg.remote_override};
                            end else begin
                                d.cfg.remote_override = q.arg_val[0];
                            end
                        end
                        `RSC_CMD_TRIGGER: begin
                            d.trigger = 1'b1;
                            d.irq_sts[`RSC_IRQ_TRIGGER] = 1'b1;
                        end
                        `RSC_CMD_CLEAR: begin
                            d.event_status = 8'h00;
                            d.fault_status = fault_events;
                        end
                        `RSC_CMD_EVT_EN: begin
                            if (is_query) begin
                                d.result = rsc_pick(q.cfg.event_enable, is_bit, q.arg_idx);
                            end else begin
                                d.cfg.event_enable = rsc_upd(q.cfg.event_enable, is_bit,
                                                             q.arg_idx, q.arg_val);
                            end
                        end
                        `RSC_CMD_EVT_STS: begin
                            d.result = rsc_pick(q.event_status, is_bit, q.arg_idx);
                        end
                        `RSC_CMD_POLL_EN: begin
                            if (is_query) begin
                                d.result = rsc_pick(q.cfg.poll_enable, is_bit, q.arg_idx);
                            end else begin
                                d.cfg.poll_enable = rsc_upd(q.cfg.poll_enable, is_bit,
                                                            q.arg_idx, q.arg_val);
                            end
                        end
                        `RSC_CMD_POLL_STS: begin
                            d.result = rsc_pick(poll_status, is_bit, q.arg_idx);
                        end
                        `RSC_CMD_PWR_CLR: begin
                            if (is_query) begin
                                d.result = {31'h00000000, q.cfg.power_on_clear};
                            end else begin
                                d.cfg.power_on_clear = q.arg_val[0];
                            end
                        end
                        `RSC_CMD_FAULT_EN: begin
                            if (is_query) begin
                                d.result = rsc_pick(q.cfg.fault_enable_mask, is_bit, q.arg_idx);
                            end else begin
                                d.cfg.fault_enable_mask = rsc_upd(q.cfg.fault_enable_mask,
                                                                  is_bit, q.arg_idx,
                                                                  q.arg_val);
                            end
                        end
                        `RSC_CMD_FAULT_STS: begin
                            d.result = rsc_pick(q.fault_status, is_bit, q.arg_idx);
                        end
                        default: begin
                            d.result = `RSC_RESULT_BAD;
                            d.irq_sts[`RSC_IRQ_REJECT] = 1'b1;
                        end
                    endcase
                end
            end
            RSC_ANS: begin
                // ROM word arrives one cycle after its address
                if (!q.id_rd) begin
                    d.result = id_word;
                    d.st     = RSC_IDLE;
                end
            end
            default: begin
                d.st = RSC_IDLE;
            end
        endcase

        // ************************************************************
        // Avalon slave: one wait cycle, then answer
        // ************************************************************
        if (bus_req && q.waitreq) begin
            d.waitreq = 1'b0;
            d.rdata   = 32'h00000000;
            case (avs_address)
                `RSC_ARG_OFS:     d.rdata = {q.arg_val, q.arg_idx};
                `RSC_RESULT_OFS:  d.rdata = q.result;
                `RSC_STATE_OFS:   d.rdata = {8'h00, poll_status, q.event_status,
                                             5'h00, q.st};
                `RSC_IRQ_STS_OFS: d.rdata = {29'h00000000, q.irq_sts};
                `RSC_IRQ_MSK_OFS: d.rdata = {29'h00000000, q.irq_msk};
                `RSC_FAULT_OFS:   d.rdata = {24'h000000, q.fault_status};
                default:          d.rdata = 32'h00000000;
            endcase
        end else if (!q.waitreq) begin
            d.waitreq = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
                case (avs_address)
                    `RSC_CMD_OFS: begin
                        // Commands during execution are dropped; host waits
                        if (q.st == RSC_IDLE) begin
                            d.cmd = avs_writedata;
                            d.st  = RSC_EXEC;
                        end
                    end
                    `RSC_ARG_OFS: begin
                        d.arg_idx = avs_writedata[15:0];
                        d.arg_val = avs_writedata[31:16];
                    end
                    `RSC_IRQ_MSK_OFS: d.irq_msk = avs_writedata[2:0];
                    default: d.waitreq = 1'b1;
                endcase
            end
        end
        d.irq = |(d.irq_sts & d.irq_msk);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q         <= '0;
            q.st      <= RSC_IDLE;
            q.waitreq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata        = q.rdata;
    assign avs_waitrequest     = q.waitreq;
    assign trigger_pulse       = q.trigger;
    assign local_remote_select = q.cfg.local_remote_select;
    assign remote_override     = q.cfg.remote_override;
    assign irq                 = q.irq;
endmodule // rsc_handler
`default_nettype wire

// >>> rtl/rsc_id_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module rsc_id_rom (
    input  wire logic                   clk,
    input  wire logic [`RSC_ID_AW-1:0]  addr,
    output logic      [31:0]            data
);
    // Arbitrary neutral identity text, four ASCII chars a word
    logic [31:0] rom [`RSC_ID_WORDS];
    assign rom[0] = 32'h47454e45;
    assign rom[1] = 32'h5249432c;
    assign rom[2] = 32'h4c4f434b;
    assign rom[3] = 32'h2c303030;

    always_ff @(posedge clk) begin
        data <= rom[addr];
    end
endmodule // rsc_id_rom
`default_nettype wire

// >>> rtl/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// Summary of operation
// - Reset command restores all settings except the power-on clear flag to defaults
// - Identification query returns readable ID string
// - Local/remote state: 0 local, 1 remote, 2 lockout
// - Remote override state: 0 off, 1 on
// - Software trigger equals hardware trigger edge
// - Clear-status clears the event and fault status bytes
// - Event enable mask: 8-bit, whole-byte write/read
// - Event enable: two-argument bit set, bit query
// - Event status query: byte or single bit
// - Serial poll enable mask: 8-bit, whole byte
// - Serial poll enable: bit set, bit query
// - Serial poll status query: byte or bit
// - Power-on status clear flag settable and queryable
// - Fault enable mask: byte or single-bit write
// - Poll bit0 acquisition idle, bit1 command idle
// - Poll bit2: any enabled fault bit set
// - Poll bit3: any enabled measurement bit set

// ****************************************************************
// Register offsets (word addresses)
// ****************************************************************
`define RSC_CMD_OFS     4'h0
`define RSC_ARG_OFS     4'h1
`define RSC_RESULT_OFS  4'h2
`define RSC_STATE_OFS   4'h3
`define RSC_IRQ_STS_OFS 4'h4
`define RSC_IRQ_MSK_OFS 4'h5
`define RSC_ID_OFS      4'h6
`define RSC_FAULT_OFS   4'h7

// ****************************************************************
// Command field layout and codes
// ****************************************************************
`define RSC_CMD_QUERY_BIT 8
`define RSC_CMD_BIT_BIT   9
`define RSC_CMD_RESET     4'h1
`define RSC_CMD_IDENT     4'h2
`define RSC_CMD_LOCAL     4'h3
`define RSC_CMD_OVERRIDE  4'h4
`define RSC_CMD_TRIGGER   4'h5
`define RSC_CMD_CLEAR     4'h6
`define RSC_CMD_EVT_EN    4'h7
`define RSC_CMD_EVT_STS   4'h8
`define RSC_CMD_POLL_EN   4'h9
`define RSC_CMD_POLL_STS  4'ha
`define RSC_CMD_PWR_CLR   4'hb
`define RSC_CMD_FAULT_EN  4'hc
`define RSC_CMD_FAULT_STS 4'hd

// ****************************************************************
// Values and limits
// ****************************************************************
`define RSC_BYTE_MAX      16'h00ff
`define RSC_BIT_MAX       16'h0007
`define RSC_LOCAL_LOCKOUT 2'h2
`define RSC_POLL_ACQ_IDLE 0
`define RSC_POLL_CMD_IDLE 1
`define RSC_POLL_FAULT    2
`define RSC_POLL_MEAS     3
`define RSC_EVT_CMD_ERR   5
`define RSC_IRQ_DONE      0
`define RSC_IRQ_REJECT    1
`define RSC_IRQ_TRIGGER   2
`define RSC_ID_WORDS      4
`define RSC_ID_AW         2
`define RSC_RESULT_BAD    32'hffffffff
`endif

// >>> rtl/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
    typedef enum logic [2:0] {
        RSC_IDLE = 3'b001,
        RSC_EXEC = 3'b010,
        RSC_ANS  = 3'b100
    } rsc_state_t;

    typedef struct packed {
        logic [1:0] local_remote_select;
        logic       remote_override;
        logic       power_on_clear;
        logic [7:0] event_enable;
        logic [7:0] poll_enable;
        logic [7:0] fault_enable_mask;
    } rsc_cfg_t;

    typedef struct packed {
        rsc_state_t  st;
        rsc_cfg_t    cfg;
        logic [31:0] cmd;
        logic [15:0] arg_idx;
        logic [15:0] arg_val;
        logic [31:0] result;
        logic [7:0]  event_status;
        logic [7:0]  fault_status;
        logic [2:0]  irq_sts;
        logic [2:0]  irq_msk;
        logic        trig_prev;
        logic        trigger;
        logic        irq;
        logic        waitreq;
        logic [31:0] rdata;
        logic        id_rd;
        logic [1:0]  id_idx;
    } rsc_regs_t;
endpackage
`default_nettype wire

// >>> tb/rsc_handler_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_handler_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        hw_trigger,
    input wire logic        acquiring,
    input wire logic        meas_summary,
    input wire logic [7:0]  fault_events,
    input wire logic        trigger_pulse,
    input wire logic [1:0]  local_remote_select,
    input wire logic        remote_override,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_taken |=> s_answer)
        else $error("bus answer not one cycle");
    a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without request");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest
        && (avs_address == 4'h6 || avs_address[3]) |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_trig_hw: assert property ($rose(hw_trigger) |=> trigger_pulse)
        else $error("no pulse after trigger edge");
    a_trig_single: assert property (trigger_pulse |=> !trigger_pulse)
        else $error("trigger pulse too long");
    a_local_range: assert property (local_remote_select != 2'h3)
        else $error("illegal local state");
    a_cfg_by_cmd: assert property ($changed({local_remote_select, remote_override})
        |-> $past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3)
        || $past(avs_write, 4) || $past(avs_write, 5))
        else $error("state changed without command");
    a_acq_idle: assert property (avs_read && avs_waitrequest && avs_address == 4'h3
        && $stable(acquiring) && acquiring == $past(acquiring, 2)
        |=> avs_readdata[16] == !acquiring)
        else $error("acquisition idle bit wrong");
    a_meas_sum: assert property (avs_read && avs_waitrequest && avs_address == 4'h3
        && $stable(meas_summary) && meas_summary == $past(meas_summary, 2)
        |=> avs_readdata[19] == meas_summary)
        else $error("measurement summary bit wrong");
endmodule // rsc_handler_checker
bind rsc_handler rsc_handler_checker rsc_handler_checker_i (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hw_trigger(hw_trigger), .acquiring(acquiring), .meas_summary(meas_summary),
    .fault_events(fault_events), .trigger_pulse(trigger_pulse),
    .local_remote_select(local_remote_select), .remote_override(remote_override), .irq(irq));
`default_nettype wire

// >>> tb/rsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
    input  wire logic        clk,
    output logic      [3:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    logic hung = 1'b0;
    initial begin
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
    end
    // ********
    // One bus cycle, held until the slave answers
    // ********
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        hung = (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // Released data must not look valid
        avs_writedata <= ~d;
    endtask
endmodule // rsc_host
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module tb_top;
    logic        clk;
    logic        nrst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        hw_trigger;
    logic        acquiring;
    logic        meas_summary;
    logic [7:0]  fault_events;
    logic        trigger_pulse;
    logic [1:0]  local_remote_select;
    logic        remote_override;
    logic        irq;
    logic [31:0] r;
    int          mismatches = 0;
    int          num_checks = 0;
    int          pulses = 0;
    logic [3:0]  ops [3] = '{`RSC_CMD_EVT_EN, `RSC_CMD_POLL_EN, `RSC_CMD_FAULT_EN};

    rsc_handler rsc_handler_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hw_trigger(hw_trigger), .acquiring(acquiring),
        .meas_summary(meas_summary), .fault_events(fault_events),
        .trigger_pulse(trigger_pulse), .local_remote_select(local_remote_select),
        .remote_override(remote_override), .irq(irq));
    rsc_host rsc_host_i (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    always @(negedge clk) if (trigger_pulse === 1'b1) pulses <= pulses + 1;

    // ********
    // Shared tasks
    // ********
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        rsc_host_i.xfer(w, a, d, q);
        if (rsc_host_i.hung) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic cmd(input logic [3:0] op, input logic [1:0] qb, input logic [15:0] idx,
                       input logic [15:0] val, output logic [31:0] res);
        logic [31:0] q;
        int n;
        rw(1'b1, `RSC_ARG_OFS, (qb == 2'b00) ? {idx, 16'h0} : {val, idx}, q);
        rw(1'b1, `RSC_CMD_OFS, {22'h0, qb, 4'h0, op}, q);
        n = 0;
        do begin
            rw(1'b0, `RSC_STATE_OFS, 32'h0, q);
            n++;
        end while (q[17] !== 1'b1 && n < 20);
        if (q[17] !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        rw(1'b0, `RSC_RESULT_OFS, 32'h0, res);
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 8) begin
            @(negedge clk);
            n++;
        end
        check("irq", {31'h0, irq}, {31'h0, lvl});
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset_state();
        rw(1'b0, `RSC_STATE_OFS, 32'h0, r);
        check("idle state", {16'h0, r[23:8]}, 32'h0300);
        check("outputs", {28'h0, local_remote_select, remote_override, irq}, 32'h0);
        rw(1'b0, 4'h6, 32'h0, r);
        check("unmapped 6", r, 32'h0);
        rw(1'b1, 4'h9, 32'h1234, r);
        rw(1'b0, 4'h9, 32'h0, r);
        check("unmapped 9", r, 32'h0);
    endtask
    task automatic t_lr_ovr();
        for (int i = 2; i >= 0; i--) begin
            cmd(`RSC_CMD_LOCAL, 2'b00, 16'(i), 16'h0, r);
            cmd(`RSC_CMD_OVERRIDE, 2'b00, 16'(i % 2), 16'h0, r);
            check("local port", {30'h0, local_remote_select}, 32'(i));
            check("override port", {31'h0, remote_override}, 32'(i % 2));
            cmd(`RSC_CMD_LOCAL, 2'b01, 16'h0, 16'h0, r);
            check("local query", r, 32'(i));
            cmd(`RSC_CMD_OVERRIDE, 2'b01, 16'h0, 16'h0, r);
            check("override query", r, 32'(i % 2));
        end
    endtask
    task automatic t_masks();
        foreach (ops[k]) begin
            cmd(ops[k], 2'b00, 16'h00ff, 16'h0, r);
            cmd(ops[k], 2'b01, 16'h0, 16'h0, r);
            check("mask full", r, 32'hff);
            cmd(ops[k], 2'b00, 16'h00a5, 16'h0, r);
            cmd(ops[k], 2'b10, 16'h6, 16'h1, r);
            cmd(ops[k], 2'b10, 16'h0, 16'h0, r);
            cmd(ops[k], 2'b00, 16'h0100, 16'h0, r);
            check("byte over", r, `RSC_RESULT_BAD);
            cmd(ops[k], 2'b10, 16'h8, 16'h1, r);
            check("index over", r, `RSC_RESULT_BAD);
            cmd(ops[k], 2'b10, 16'h1, 16'h2, r);
            check("value over", r, `RSC_RESULT_BAD);
            cmd(ops[k], 2'b01, 16'h0, 16'h0, r);
            check("mask byte", r, 32'he4);
            cmd(ops[k], 2'b11, 16'h6, 16'h0, r);
            check("mask bit", r, 32'h1);
        end
    endtask
    task automatic t_status();
        cmd(`RSC_CMD_EVT_STS, 2'b11, 16'h5, 16'h0, r);
        check("event bit", r, 32'h1);
        @(posedge clk);
        fault_events <= 8'h01;
        acquiring    <= 1'b1;
        meas_summary <= 1'b1;
        @(posedge clk);
        fault_events <= 8'h00;
        rw(1'b0, `RSC_STATE_OFS, 32'h0, r);
        check("masked fault", {28'h0, r[19:16]}, 32'ha);
        @(posedge clk);
        fault_events <= 8'h04;
        @(posedge clk);
        fault_events <= 8'h00;
        rw(1'b0, `RSC_STATE_OFS, 32'h0, r);
        check("poll nibble", {28'h0, r[19:16]}, 32'he);
        rw(1'b0, `RSC_FAULT_OFS, 32'h0, r);
        check("fault status", r, 32'h05);
        cmd(`RSC_CMD_POLL_STS, 2'b11, 16'h2, 16'h0, r);
        check("poll bit", r, 32'h1);
        @(posedge clk);
        acquiring    <= 1'b0;
        meas_summary <= 1'b0;
        cmd(`RSC_CMD_CLEAR, 2'b00, 16'h0, 16'h0, r);
        rw(1'b0, `RSC_STATE_OFS, 32'h0, r);
        check("cleared", {16'h0, r[23:8]}, 32'h0300);
        rw(1'b0, `RSC_FAULT_OFS, 32'h0, r);
        check("fault cleared", r, 32'h0);
    endtask
    task automatic t_trigger();
        int p;
        p = pulses;
        rw(1'b1, `RSC_IRQ_STS_OFS, 32'h7, r);
        rw(1'b1, `RSC_IRQ_MSK_OFS, 32'h4, r);
        @(posedge clk);
        hw_trigger <= 1'b1;
        wait_irq(1'b1);
        @(posedge clk);
        hw_trigger <= 1'b0;
        check("hw pulses", 32'(pulses), 32'(p + 1));
        rw(1'b1, `RSC_IRQ_STS_OFS, 32'h4, r);
        wait_irq(1'b0);
        rw(1'b1, `RSC_IRQ_MSK_OFS, 32'h0, r);
        cmd(`RSC_CMD_TRIGGER, 2'b00, 16'h0, 16'h0, r);
        check("cmd pulses", 32'(pulses), 32'(p + 2));
        rw(1'b0, `RSC_IRQ_STS_OFS, 32'h0, r);
        check("trigger status", {31'h0, r[2]}, 32'h1);
        check("masked irq", {31'h0, irq}, 32'h0);
        rw(1'b1, `RSC_IRQ_STS_OFS, 32'h7, r);
    endtask
    task automatic t_ident();
        for (int w = 0; w < `RSC_ID_WORDS; w++) begin
            cmd(`RSC_CMD_IDENT, 2'b01, 16'(w), 16'h0, r);
            for (int b = 0; b < 4; b++)
                check("id char", {31'h0, r[8*b+:8] inside {8'h00, [8'h20:8'h7e]}}, 32'h1);
        end
    endtask
    task automatic t_reset_cmd();
        cmd(`RSC_CMD_PWR_CLR, 2'b00, 16'h1, 16'h0, r);
        cmd(`RSC_CMD_LOCAL, 2'b00, 16'h2, 16'h0, r);
        cmd(`RSC_CMD_OVERRIDE, 2'b00, 16'h1, 16'h0, r);
        cmd(`RSC_CMD_RESET, 2'b00, 16'h0, 16'h0, r);
        check("reset outputs", {29'h0, local_remote_select, remote_override}, 32'h0);
        foreach (ops[k]) begin
            cmd(ops[k], 2'b01, 16'h0, 16'h0, r);
            check("reset mask", r, 32'h0);
        end
        cmd(`RSC_CMD_PWR_CLR, 2'b01, 16'h0, 16'h0, r);
        check("power clear kept", r, 32'h1);
        cmd(`RSC_CMD_PWR_CLR, 2'b00, 16'h0, 16'h0, r);
        cmd(`RSC_CMD_PWR_CLR, 2'b01, 16'h0, 16'h0, r);
        check("power clear off", r, 32'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        nrst         = 1'b0;
        hw_trigger   = 1'b0;
        acquiring    = 1'b0;
        meas_summary = 1'b0;
        fault_events = 8'h00;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset_state();
        t_lr_ovr();
        t_masks();
        t_status();
        t_trigger();
        t_ident();
        t_reset_cmd();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
